// ==== hdl/scpa_pkg.sv ====
package scpa_pkg;
   // Instruction word layout
   localparam int INSTR_BITS = 16;
   localparam int ADDR_BITS = 13;
   localparam int RW_POS = 15;
   localparam int LEN_HI_POS = 14;
   localparam int LEN_LO_POS = 13;
   localparam int BYTE_BITS = 8;
   // Transfer length codes
   localparam logic [1:0] LEN_ONE = 2'h0;
   localparam logic [1:0] LEN_TWO = 2'h1;
   localparam logic [1:0] LEN_THREE = 2'h2;
   localparam logic [1:0] LEN_STREAM = 2'h3;
   // Register addresses and bit positions
   localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
   localparam logic [12:0] ADDR_STATUS_CFG = 13'h232;
   localparam logic [12:0] ADDR_COMMIT = 13'h234;
   localparam logic [12:0] ADDR_NVM_STAT = 13'hb00;
   localparam logic [12:0] ADDR_LOW_END = 13'h000;
   localparam logic [12:0] ADDR_HIGH_END = 13'h234;
   localparam int LSB_FIRST_POS_A = 1;
   localparam int LSB_FIRST_POS_B = 6;
   localparam int MON_BUSY_POS = 4;
   localparam int COMMIT_POS = 0;
   localparam logic RESET_LSB_FIRST = 1'b0;
   localparam logic RESET_MON_BUSY = 1'b0;
   // Timing
   localparam int CLK_KHZ = 250000;
   localparam int SAVE_TIME_MS = 46;
   localparam int LOAD_TIME_MS = 40;
   localparam int START_TIME_NS = 2000;
   localparam int SAVE_CYCLES = SAVE_TIME_MS * CLK_KHZ;
   localparam int LOAD_CYCLES = LOAD_TIME_MS * CLK_KHZ;
   localparam int START_CYCLES = START_TIME_NS * (CLK_KHZ / 1000) / 1000;
   localparam int TIMER_BITS = 24;
   localparam int NVM_BYTES = 512;

   typedef enum logic [1:0] {SCPA_IDLE, SCPA_INSTR, SCPA_DATA, SCPA_DONE} scpa_state_t;
endpackage

// ==== hdl/scpa_serial_port.sv ====
`timescale 1ns/1ns
module scpa_serial_port #(
   parameter int SAVE_CYC = scpa_pkg::SAVE_CYCLES,
   parameter int LOAD_CYC = scpa_pkg::LOAD_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csB,
   input wire logic sdioIn,
   output logic sdioOut,
   output logic sdioOe,
   output logic serialDataOut,
   output logic serialDataOutOe,
   output logic regWrStrobe,
   output logic [scpa_pkg::ADDR_BITS-1:0] regWrAddr,
   output logic [scpa_pkg::BYTE_BITS-1:0] regWrData,
   output logic [scpa_pkg::ADDR_BITS-1:0] regRdAddr,
   input wire logic [scpa_pkg::BYTE_BITS-1:0] regRdData,
   output logic commitPulse,
   input wire logic nvmSaveStart,
   input wire logic nvmLoadStart,
   output logic busyFlag,
   output logic i2cAddrAck,
   output logic monitorOutputPinA,
   input wire logic resetPinB,
   input wire logic nvmSelPin,
   output logic restorePulse,
   output logic restoreFromNvm,
   output logic syncPulse,
   output logic outputsRunning
);
   import scpa_pkg::*;

   typedef struct packed {
      scpa_state_t st;
      logic sclkS1;
      logic sclkS2;
      logic sclkS3;
      logic csS1;
      logic csS2;
      logic dinS1;
      logic dinS2;
      logic rpS1;
      logic rpS2;
      logic rpS3;
      logic selS1;
      logic selS2;
      logic [3:0] bitCnt;
      logic [15:0] sh;
      logic rw;
      logic [1:0] len;
      logic [12:0] addr;
      logic [1:0] byteCnt;
      logic past;
      logic lsbFirst;
      logic monEn;
      logic [7:0] txByte;
      logic txLoad;
      logic txBit;
      logic wrStb;
      logic [12:0] wrAddr;
      logic [7:0] wrData;
      logic commit;
      logic [23:0] busyCnt;
      logic [23:0] startCnt;
      logic waitNvm;
      logic running;
      logic syncP;
      logic restP;
      logic fromNvm;
   } scpa_regs_t;

   scpa_regs_t r_r;
   scpa_regs_t r_nxt;

   logic sclkRise;
   logic sclkFall;
   logic busy;
   logic [7:0] rdVal;
   logic [15:0] instrWord;
   logic [7:0] dataByte;
   logic nextPast;
   logic lastByte;

   // Timer lengths must fit the busy counter
   if (SAVE_CYC < 1 || SAVE_CYC >= 2 ** TIMER_BITS) begin : g_bad_save
      $error("SAVE_CYC out of range");
   end
   if (LOAD_CYC < 1 || LOAD_CYC >= 2 ** TIMER_BITS) begin : g_bad_load
      $error("LOAD_CYC out of range");
   end

   assign sclkRise = r_r.sclkS2 & ~r_r.sclkS3;
   assign sclkFall = ~r_r.sclkS2 & r_r.sclkS3;
   assign busy = (r_r.busyCnt != 24'h0);

   always_comb begin
      // Read data source with blocking and boundary handling
      if (r_r.past) begin
         rdVal = 8'h00;
      end else if (r_r.addr == ADDR_NVM_STAT) begin
         rdVal = {7'h00, busy};
      end else if (busy) begin
         rdVal = 8'h00;
      end else begin
         rdVal = regRdData;
      end
   end

   always_comb begin
      // Assembled words in the active bit order
      if (r_r.lsbFirst) begin
         instrWord = {r_r.dinS2, r_r.sh[15:1]};
         dataByte = {r_r.dinS2, r_r.sh[15:9]};
      end else begin
         instrWord = {r_r.sh[14:0], r_r.dinS2};
         dataByte = {r_r.sh[6:0], r_r.dinS2};
      end
      if (r_r.lsbFirst) begin
         nextPast = r_r.past | (r_r.addr == ADDR_HIGH_END);
      end else begin
         nextPast = r_r.past | (r_r.addr == ADDR_LOW_END);
      end
      if (r_r.len == LEN_STREAM) begin
         lastByte = nextPast;
      end else begin
         lastByte = (r_r.byteCnt == r_r.len);
      end
   end

   always_comb begin
      r_nxt = r_r;
      r_nxt.sclkS1 = sclk;
      r_nxt.sclkS2 = r_r.sclkS1;
      r_nxt.sclkS3 = r_r.sclkS2;
      r_nxt.csS1 = csB;
      r_nxt.csS2 = r_r.csS1;
      r_nxt.dinS1 = sdioIn;
      r_nxt.dinS2 = r_r.dinS1;
      r_nxt.rpS1 = resetPinB;
      r_nxt.rpS2 = r_r.rpS1;
      r_nxt.rpS3 = r_r.rpS2;
      r_nxt.selS1 = nvmSelPin;
      r_nxt.selS2 = r_r.selS1;
      r_nxt.wrStb = 1'b0;
      r_nxt.commit = 1'b0;
      r_nxt.txLoad = 1'b0;
      r_nxt.syncP = 1'b0;
      r_nxt.restP = 1'b0;

      // Transfer-busy timer
      if (r_r.busyCnt != 24'h0) begin
         r_nxt.busyCnt = r_r.busyCnt - 24'h1;
      end
      if (nvmSaveStart) begin
         r_nxt.busyCnt = SAVE_CYC[23:0];
      end else if (nvmLoadStart) begin
         r_nxt.busyCnt = LOAD_CYC[23:0];
      end

      // Serial engine
      if (r_r.txLoad) begin
         r_nxt.txByte = rdVal;
      end
      if (r_r.csS2) begin
         if (r_r.st == SCPA_DONE || (r_r.st == SCPA_DATA && r_r.len == LEN_STREAM)) begin
            r_nxt.st = SCPA_IDLE;
         end else if (r_r.st == SCPA_INSTR && r_r.bitCnt[2:0] != 3'h0) begin
            r_nxt.st = SCPA_IDLE;
         end else if (r_r.st == SCPA_DATA && r_r.bitCnt != 4'h0) begin
            r_nxt.st = SCPA_IDLE;
         end
      end else begin
         if (r_r.st == SCPA_IDLE) begin
            r_nxt.st = SCPA_INSTR;
            r_nxt.bitCnt = 4'h0;
         end
         if (sclkRise) begin
            case (r_r.st)
               SCPA_IDLE: begin
                  r_nxt.sh = {r_r.sh[14:0], r_r.dinS2};
                  r_nxt.bitCnt = 4'h1;
                  if (r_r.lsbFirst) begin
                     r_nxt.sh = {r_r.dinS2, r_r.sh[15:1]};
                  end
               end
               SCPA_INSTR: begin
                  r_nxt.sh = instrWord;
                  r_nxt.bitCnt = r_r.bitCnt + 4'h1;
                  if (r_r.bitCnt == 4'hf) begin
                     r_nxt.rw = instrWord[RW_POS];
                     r_nxt.len = instrWord[LEN_HI_POS:LEN_LO_POS];
                     r_nxt.addr = instrWord[ADDR_BITS-1:0];
                     r_nxt.st = SCPA_DATA;
                     r_nxt.byteCnt = 2'h0;
                     r_nxt.past = 1'b0;
                     r_nxt.txLoad = instrWord[RW_POS];
                     r_nxt.bitCnt = 4'h0;
                  end
               end
               SCPA_DATA: begin
                  r_nxt.sh = r_r.lsbFirst ? {r_r.dinS2, r_r.sh[15:1]} : {r_r.sh[14:0], r_r.dinS2};
                  r_nxt.bitCnt = r_r.bitCnt + 4'h1;
                  if (r_r.bitCnt == 4'h7) begin
                     r_nxt.bitCnt = 4'h0;
                     if (!r_r.rw && !r_r.past && !busy) begin
                        r_nxt.wrStb = 1'b1;
                        r_nxt.wrAddr = r_r.addr;
                        r_nxt.wrData = dataByte;
                        if (r_r.addr == ADDR_PORT_CFG) begin
                           r_nxt.lsbFirst = dataByte[LSB_FIRST_POS_A] | dataByte[LSB_FIRST_POS_B];
                        end
                        if (r_r.addr == ADDR_STATUS_CFG) begin
                           r_nxt.monEn = dataByte[MON_BUSY_POS];
                        end
                        if (r_r.addr == ADDR_COMMIT) begin
                           r_nxt.commit = dataByte[COMMIT_POS];
                        end
                     end
                     r_nxt.past = nextPast;
                     if (r_r.lsbFirst) begin
                        r_nxt.addr = r_r.addr + 13'h1;
                     end else begin
                        r_nxt.addr = r_r.addr - 13'h1;
                     end
                     if (lastByte) begin
                        r_nxt.st = SCPA_DONE;
                        r_nxt.txByte = 8'h00;
                     end else begin
                        r_nxt.byteCnt = r_r.byteCnt + 2'h1;
                        r_nxt.txLoad = r_r.rw;
                     end
                  end
               end
               default: begin
                  r_nxt.bitCnt = 4'h0;
               end
            endcase
         end
         // Read bits leave on falling edges
         if (sclkFall && r_r.rw && (r_r.st == SCPA_DATA || r_r.st == SCPA_DONE)) begin
            if (r_r.lsbFirst) begin
               r_nxt.txBit = r_r.txByte[0];
               r_nxt.txByte = {1'b0, r_r.txByte[7:1]};
            end else begin
               r_nxt.txBit = r_r.txByte[7];
               r_nxt.txByte = {r_r.txByte[6:0], 1'b0};
            end
         end
      end

      // Reset pin, restore and output start-up
      if (!r_r.rpS2) begin
         r_nxt.st = SCPA_IDLE;
         r_nxt.lsbFirst = RESET_LSB_FIRST;
         r_nxt.monEn = RESET_MON_BUSY;
         r_nxt.running = 1'b0;
         r_nxt.waitNvm = 1'b0;
         r_nxt.startCnt = 24'h0;
      end else if (!r_r.rpS3) begin
         r_nxt.restP = 1'b1;
         r_nxt.syncP = 1'b1;
         r_nxt.fromNvm = r_r.selS2;
         if (r_r.selS2) begin
            r_nxt.busyCnt = LOAD_CYC[23:0];
            r_nxt.waitNvm = 1'b1;
         end else begin
            r_nxt.startCnt = START_CYCLES[23:0];
         end
      end else begin
         if (r_r.startCnt != 24'h0) begin
            r_nxt.startCnt = r_r.startCnt - 24'h1;
            r_nxt.running = (r_r.startCnt == 24'h1);
         end
         if (r_r.waitNvm && r_r.busyCnt == 24'h1) begin
            r_nxt.waitNvm = 1'b0;
            r_nxt.running = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r_r <= '0;
         r_r.st <= SCPA_IDLE;
         r_r.sclkS1 <= 1'b0;
         r_r.csS1 <= 1'b1;
         r_r.csS2 <= 1'b1;
         r_r.rpS1 <= 1'b1;
         r_r.rpS2 <= 1'b1;
         r_r.rpS3 <= 1'b1;
         r_r.lsbFirst <= RESET_LSB_FIRST;
         r_r.monEn <= RESET_MON_BUSY;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign sdioOut = r_r.txBit;
   assign serialDataOut = r_r.txBit;
   assign sdioOe = ~r_r.csS2 & r_r.rw & (r_r.st == SCPA_DATA || r_r.st == SCPA_DONE);
   assign serialDataOutOe = sdioOe;
   assign regWrStrobe = r_r.wrStb;
   assign regWrAddr = r_r.wrAddr;
   assign regWrData = r_r.wrData;
   assign regRdAddr = r_r.addr;
   assign commitPulse = r_r.commit;
   assign busyFlag = busy;
   assign i2cAddrAck = ~busy;
   assign monitorOutputPinA = r_r.monEn & busy;
   assign restorePulse = r_r.restP;
   assign restoreFromNvm = r_r.fromNvm;
   assign syncPulse = r_r.syncP;
   assign outputsRunning = r_r.running;
endmodule // scpa_serial_port

// ==== tb/scpa_serial_port_asserts.sv ====
`timescale 1ns/1ns
module scpa_serial_port_asserts #(
   parameter int SAVE_CYC = 50,
   parameter int LOAD_CYC = 50
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic csB,
   input wire logic sdioOe,
   input wire logic regWrStrobe,
   input wire logic [scpa_pkg::ADDR_BITS-1:0] regWrAddr,
   input wire logic [scpa_pkg::BYTE_BITS-1:0] regWrData,
   input wire logic commitPulse,
   input wire logic nvmSaveStart,
   input wire logic busyFlag,
   input wire logic i2cAddrAck,
   input wire logic monitorOutputPinA,
   input wire logic restorePulse,
   input wire logic syncPulse
);
   import scpa_pkg::*;
   int busyLen;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clk) begin
      if (!rst_b || !busyFlag) begin
         busyLen <= 0;
      end else begin
         busyLen <= busyLen + 1;
      end
   end
   sequence pulseS; restorePulse && syncPulse; endsequence
   sequence quietS; !restorePulse && !syncPulse; endsequence
   ack_busy_a: assert property (i2cAddrAck == !busyFlag)
      else $error("ack wrong");
   mon_busy_a: assert property (monitorOutputPinA |-> busyFlag)
      else $error("monitor without busy");
   busy_start_a: assert property (nvmSaveStart |-> ##[1:2] busyFlag)
      else $error("busy not raised");
   busy_len_a: assert property ($fell(busyFlag) |-> busyLen >= LOAD_CYC - 2)
      else $error("busy too short");
   busy_max_a: assert property (busyLen <= SAVE_CYC + 2)
      else $error("busy too long");
   wr_idle_a: assert property (regWrStrobe |-> !busyFlag)
      else $error("write while busy");
   wr_range_a: assert property (regWrStrobe |-> regWrAddr <= ADDR_HIGH_END)
      else $error("write past end");
   commit_addr_a: assert property (commitPulse |-> regWrAddr == ADDR_COMMIT)
      else $error("commit wrong");
   cs_idle_a: assert property (csB [*4] |-> !sdioOe)
      else $error("drives while deselected");
   release_pulse_a: assert property (restorePulse |-> pulseS ##1 quietS)
      else $error("release pulses wrong");
endmodule // scpa_serial_port_asserts

bind scpa_serial_port scpa_serial_port_asserts #(.SAVE_CYC(SAVE_CYC), .LOAD_CYC(LOAD_CYC)) u_chk (
   .clk(clk), .rst_b(rst_b), .csB(csB), .sdioOe(sdioOe), .regWrStrobe(regWrStrobe),
   .regWrAddr(regWrAddr), .regWrData(regWrData), .commitPulse(commitPulse),
   .nvmSaveStart(nvmSaveStart), .busyFlag(busyFlag), .i2cAddrAck(i2cAddrAck),
   .monitorOutputPinA(monitorOutputPinA), .restorePulse(restorePulse), .syncPulse(syncPulse));

// ==== tb/scpa_spi_host.sv ====
`timescale 1ns/1ns
module scpa_spi_host (
   output logic sclk,
   output logic csB,
   output logic sdioDrv,
   input wire logic sdioWire
);
   int hp = 16;
   logic [7:0] rdByte = 8'h00;
   initial begin
      sclk = 1'b0;
      csB = 1'b1;
      sdioDrv = 1'b0;
   end
   // Sample just before the rising edge
   task automatic bitx(input logic b);
      sdioDrv = b;
      #hp rdByte = {rdByte[6:0], sdioWire};
      sclk = 1'b1;
      #hp sclk = 1'b0;
   endtask
   task automatic frame(input logic lsb, input logic [15:0] ins, input int nb,
         input logic [7:0] d, input int cut);
      csB = 1'b0;
      #hp;
      for (int i = 0; i < 16; i++) bitx(ins[lsb ? i : 15 - i]);
      for (int n = 0; n < nb * 8; n++) begin
         if (cut != 0 && n == cut) break;
         bitx(ins[15] ? ~sdioDrv : d[lsb ? n % 8 : 7 - n % 8]);
      end
      #hp csB = 1'b1;
      sdioDrv = ~sdioDrv;
      #(4 * hp);
   endtask
endmodule // scpa_spi_host

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
   import scpa_pkg::*;
   localparam int SAVE_T = 2000;
   localparam int LOAD_T = 1500;
   typedef struct {logic [15:0] ins; int nb; logic [15:0] nw; logic [15:0] a0;} scpa_row_t;
   scpa_row_t rows [5] = '{'{16'h0010, 1, 16'h1, 16'h010}, '{16'h2011, 2, 16'h2, 16'h011},
      '{16'h4002, 3, 16'h3, 16'h002}, '{16'h6001, 4, 16'h2, 16'h001},
      '{16'h2000, 2, 16'h1, 16'h000}};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic nvmSaveStart = 1'b0;
   logic nvmLoadStart = 1'b0;
   logic resetPinB = 1'b1;
   logic nvmSelPin = 1'b0;
   logic sclk, csB, sdioDrv, sdioOut, sdioOe, regWrStrobe, commitPulse, busyFlag, i2cAddrAck;
   logic monitorOutputPinA, restorePulse, restoreFromNvm, outputsRunning;
   logic serialDataOut, serialDataOutOe, syncPulse;
   logic [ADDR_BITS-1:0] regWrAddr, regRdAddr;
   logic [BYTE_BITS-1:0] regWrData;
   wire logic sdioWire = sdioOe ? sdioOut : sdioDrv;
   wire logic [BYTE_BITS-1:0] regRdData = regRdAddr[7:0] ^ 8'h5a;
   logic [ADDR_BITS-1:0] wa [$];
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int nCom = 0;
   int nRel = 0;
   int nSdo = 0;
   int n, e;
   scpa_serial_port #(.SAVE_CYC(SAVE_T), .LOAD_CYC(LOAD_T)) u_dut (
      .clk(clk), .rst_b(rst_b), .sclk(sclk), .csB(csB), .sdioIn(sdioWire), .sdioOut(sdioOut),
      .sdioOe(sdioOe), .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe),
      .regWrStrobe(regWrStrobe),
      .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdAddr(regRdAddr),
      .regRdData(regRdData), .commitPulse(commitPulse), .nvmSaveStart(nvmSaveStart),
      .nvmLoadStart(nvmLoadStart), .busyFlag(busyFlag), .i2cAddrAck(i2cAddrAck),
      .monitorOutputPinA(monitorOutputPinA), .resetPinB(resetPinB), .nvmSelPin(nvmSelPin),
      .restorePulse(restorePulse), .restoreFromNvm(restoreFromNvm), .syncPulse(syncPulse),
      .outputsRunning(outputsRunning));
   scpa_spi_host u_host (.sclk(sclk), .csB(csB), .sdioDrv(sdioDrv), .sdioWire(sdioWire));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic waitIdle();
      n = 0;
      while (busyFlag !== 1'b0 && n < SAVE_T + 10) begin
         @(negedge clk);
         n++;
      end
   endtask
   always #2 clk = ~clk;
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (regWrStrobe === 1'b1) wa.push_back(regWrAddr);
      if (commitPulse === 1'b1) nCom <= nCom + 1;
      if (restorePulse === 1'b1 && syncPulse === 1'b1) nRel <= nRel + 1;
      if (serialDataOutOe !== sdioOe || (sdioOe === 1'b1 && serialDataOut !== sdioOut)) begin
         nSdo <= nSdo + 1;
      end
      if (cyc == 40000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      foreach (rows[r]) begin
         wa.delete();
         u_host.frame(1'b0, rows[r].ins, rows[r].nb, 8'h81, 0);
         chk("writes", rows[r].nw, 16'(wa.size()));
         for (int k = 0; k < wa.size(); k++) begin
            chk("addr", rows[r].a0 - 16'(k), {3'h0, wa[k]});
         end
         chk("data", 16'h81, {8'h0, regWrData});
      end
      u_host.frame(1'b0, 16'h8010, 1, 8'h00, 0);
      chk("rd", 16'h4a, {8'h0, u_host.rdByte});
      u_host.frame(1'b0, 16'ha000, 2, 8'h00, 0);
      chk("rdzero", 16'h0, {8'h0, u_host.rdByte});
      u_host.frame(1'b0, 16'h0000, 1, 8'h42, 0);
      wa.delete();
      u_host.frame(1'b1, 16'h6233, 3, 8'h01, 0);
      chk("lsbwr", 16'h2, 16'(wa.size()));
      chk("lsbaddr", 16'h234, {3'h0, wa[$]});
      chk("commit", 16'h1, 16'(nCom));
      u_host.frame(1'b1, 16'h0000, 1, 8'h00, 0);
      wa.delete();
      u_host.frame(1'b0, 16'h0020, 1, 8'h81, 5);
      chk("abort", 16'h0, 16'(wa.size()));
      u_host.frame(1'b0, 16'h0232, 1, 8'h10, 0);
      @(negedge clk) nvmSaveStart = 1'b1;
      @(negedge clk) nvmSaveStart = 1'b0;
      repeat (3) @(negedge clk);
      chk("busy", 16'h1, {15'h0, busyFlag});
      chk("monitor", 16'h1, {15'h0, monitorOutputPinA});
      chk("ack", 16'h0, {15'h0, i2cAddrAck});
      wa.delete();
      u_host.frame(1'b0, 16'h0030, 1, 8'h81, 0);
      chk("blocked", 16'h0, 16'(wa.size()));
      u_host.frame(1'b0, 16'h8b00, 1, 8'h00, 0);
      chk("rdbusy", 16'h1, {8'h0, u_host.rdByte});
      waitIdle();
      u_host.frame(1'b0, 16'h8b00, 1, 8'h00, 0);
      chk("rdidle", 16'h0, {8'h0, u_host.rdByte});
      @(negedge clk) nvmLoadStart = 1'b1;
      @(negedge clk) nvmLoadStart = 1'b0;
      waitIdle();
      chk("loadlen", 16'h1, {15'h0, n > LOAD_T - 5 && n < LOAD_T + 5});
      for (int s = 0; s < 2; s++) begin
         nvmSelPin = s[0];
         resetPinB = 1'b0;
         repeat (5) @(negedge clk);
         resetPinB = 1'b1;
         e = s != 0 ? LOAD_T : START_CYCLES;
         n = 0;
         while (outputsRunning !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
         end
         chk("sel", {15'h0, s[0]}, {15'h0, restoreFromNvm});
         chk("start", 16'h1, {15'h0, n > e - 10 && n < e + 10});
      end
      chk("release", 16'h2, 16'(nRel));
      chk("sdo", 16'h0, 16'(nSdo));
      conclude();
   end
endmodule // testbench
